// [hw/pfdag_guard.v]
// Purpose: Frame decode and access guard between bus masters and slaves
// Assumes: One request per cycle, fixed two-cycle answer, one clock
// Notes:   Slave hit/rdata/err answer combinationally in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "pfdag_consts.vh"

module pfdag_guard #(
  parameter CNT_W = `PFDAG_CNT_W
) (
  // Clock and reset
  input  wire                    clock,
  input  wire                    rst,
  // Master request
  input  wire                    req_valid,
  input  wire                    req_write,
  input  wire [3:0]              req_master_id,
  input  wire                    req_cpu_priv,
  input  wire [31:0]             req_addr,
  input  wire [31:0]             req_wdata,
  // Master response
  output reg                     rsp_valid_q,
  output reg                     rsp_err_q,
  output reg  [31:0]             rsp_rdata_q,
  // Slave side
  output wire                    slv_rd,
  output wire                    slv_wr,
  output reg  [`PFDAG_NSEL-1:0]  slv_sel_q,
  output reg                     slv_pmm_sel_q,
  output reg                     slv_other_q,
  output reg                     slv_priv_q,
  output reg  [31:0]             slv_addr_q,
  output reg  [31:0]             slv_wdata_q,
  input  wire                    slv_hit,
  input  wire [31:0]             slv_rdata,
  input  wire                    slv_err,
  // Device state
  input  wire                    debug_mode,
  input  wire [`PFDAG_NSEL-1:0]  pd_off,
  // Events and counts
  output reg                     deny_evt_q,
  output reg                     pdoff_evt_q,
  output reg                     pmm_blk_evt_q,
  output reg  [CNT_W-1:0]        deny_cnt_q,
  output reg  [CNT_W-1:0]        pdoff_cnt_q,
  output reg  [CNT_W-1:0]        pmm_blk_cnt_q
);

  // ----------------------------------------
  // Debug mode synchroniser
  // ----------------------------------------
  reg dbg_meta_q;
  reg dbg_q;

  // Two flops, only the second is read
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      dbg_meta_q <= 1'b0;
      dbg_q      <= 1'b0;
    end else begin
      dbg_meta_q <= debug_mode;
      dbg_q      <= dbg_meta_q;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire [`PFDAG_NSEL-1:0] dec_sel;
  wire                   dec_in_frame;
  wire                   dec_is_pmm;
  wire [2:0]             dec_group;

  pfdag_frame_decode u_dec (
    .addr     (req_addr),
    .sel      (dec_sel),
    .in_frame (dec_in_frame),
    .is_pmm   (dec_is_pmm),
    .group    (dec_group)
  );

  // ----------------------------------------
  // Permission matrix
  // ----------------------------------------
  reg perm_ok;
  reg priv_d;

  // Grant per master and slave group
  always @* begin
    perm_ok = 1'b0;
    priv_d  = 1'b0;
    case (req_master_id)
      `PFDAG_MID_CPU: begin
        priv_d = req_cpu_priv;
        if (!req_write) begin
          perm_ok = 1'b1; // [RULE_08]
        end else begin
          perm_ok = (dec_group != `PFDAG_GRP_FLASH2); // [RULE_09]
        end
      end
      `PFDAG_MID_DMA,
      `PFDAG_MID_OVL,
      `PFDAG_MID_DMOD: begin
        priv_d  = 1'b0;
        perm_ok = 1'b1; // [RULE_10]
      end
      `PFDAG_MID_DBG: begin
        priv_d  = 1'b1;
        perm_ok = 1'b1; // [RULE_11]
      end
      `PFDAG_MID_TTUA,
      `PFDAG_MID_TTUB: begin
        priv_d  = 1'b1;
        perm_ok = (dec_group != `PFDAG_GRP_FLASH2); // [RULE_12]
      end
      `PFDAG_MID_ETH: begin
        priv_d  = 1'b0;
        perm_ok = (dec_group == `PFDAG_GRP_PFLASH) ||
                  (dec_group == `PFDAG_GRP_EXT); // [RULE_13]
      end
      default: begin
        priv_d  = 1'b0;
        perm_ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Power and power-manager checks
  // ----------------------------------------
  wire pd_hit;
  wire pmm_id_ok;
  wire pmm_block;

  // Target module sits in a switched-off domain
  assign pd_hit    = |(dec_sel & pd_off); // [RULE_17]
  // Only the CPU, or anyone in debug mode, may write
  assign pmm_id_ok = (req_master_id == `PFDAG_MID_CPU) || dbg_q; // [RULE_14] [RULE_16]
  assign pmm_block = dec_is_pmm && req_write && !pmm_id_ok; // [RULE_15]

  // Verdicts, matrix refusal takes priority
  wire deny_d;
  wire pdoff_d;
  wire blk_d;
  wire grant_d;

  assign deny_d  = req_valid && !perm_ok; // [RULE_18]
  assign pdoff_d = req_valid && perm_ok && pd_hit; // [RULE_17]
  assign blk_d   = req_valid && perm_ok && !pd_hit && pmm_block;
  assign grant_d = req_valid && perm_ok && !pd_hit && !pmm_block;

  // ----------------------------------------
  // Stage one: registered request
  // ----------------------------------------
  reg s1_valid_q;
  reg s1_write_q;
  reg s1_grant_q;
  reg s1_err_q;
  reg s1_in_frame_q;

  // Capture decision and forward address to slaves
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_valid_q    <= 1'b0;
      s1_write_q    <= 1'b0;
      s1_grant_q    <= 1'b0;
      s1_err_q      <= 1'b0;
      s1_in_frame_q <= 1'b0;
      slv_sel_q     <= {`PFDAG_NSEL{1'b0}};
      slv_pmm_sel_q <= 1'b0;
      slv_other_q   <= 1'b0;
      slv_priv_q    <= 1'b0;
      slv_addr_q    <= 32'h0000_0000;
      slv_wdata_q   <= 32'h0000_0000;
    end else begin
      s1_valid_q    <= req_valid;
      s1_write_q    <= req_write;
      s1_grant_q    <= grant_d;
      s1_err_q      <= deny_d || pdoff_d; // [RULE_17] [RULE_18]
      s1_in_frame_q <= dec_in_frame || dec_is_pmm;
      // Selects only for granted accesses
      slv_sel_q     <= grant_d ? dec_sel : {`PFDAG_NSEL{1'b0}}; // [RULE_18]
      slv_pmm_sel_q <= grant_d && dec_is_pmm;
      slv_other_q   <= grant_d && !dec_in_frame && !dec_is_pmm;
      slv_priv_q    <= priv_d;
      slv_addr_q    <= req_addr;
      slv_wdata_q   <= req_wdata;
    end
  end

  // ----------------------------------------
  // Slave strobes
  // ----------------------------------------
  wire loc_ok;

  // Inside a frame the slave must own the location
  assign loc_ok = slv_hit || !s1_in_frame_q; // [RULE_01]
  assign slv_rd = s1_valid_q && s1_grant_q && !s1_write_q && loc_ok;
  assign slv_wr = s1_valid_q && s1_grant_q && s1_write_q && loc_ok; // [RULE_01] [RULE_15] [RULE_18]

  // ----------------------------------------
  // Stage two: response to master
  // ----------------------------------------
  // Unowned locations read zero, denied and powered-off ones error, blocked power writes do not
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_err_q   <= 1'b0;
      rsp_rdata_q <= 32'h0000_0000;
    end else begin
      rsp_valid_q <= s1_valid_q;
      rsp_err_q   <= s1_valid_q && (s1_err_q ||
                     (s1_grant_q && !s1_in_frame_q && slv_err)); // [RULE_17] [RULE_18]
      if (slv_rd) begin
        rsp_rdata_q <= slv_rdata;
      end else begin
        rsp_rdata_q <= 32'h0000_0000; // [RULE_01]
      end
    end
  end

  // ----------------------------------------
  // Events and saturating counts
  // ----------------------------------------
  localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  // One-cycle pulse per refusal kind
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      deny_evt_q    <= 1'b0;
      pdoff_evt_q   <= 1'b0;
      pmm_blk_evt_q <= 1'b0;
    end else begin
      deny_evt_q    <= deny_d;
      pdoff_evt_q   <= pdoff_d;
      pmm_blk_evt_q <= blk_d;
    end
  end

  // Counters stop at all ones
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      deny_cnt_q    <= {CNT_W{1'b0}};
      pdoff_cnt_q   <= {CNT_W{1'b0}};
      pmm_blk_cnt_q <= {CNT_W{1'b0}};
    end else begin
      if (deny_d && (deny_cnt_q != CNT_MAX)) begin
        deny_cnt_q <= deny_cnt_q + CNT_ONE;
      end
      if (pdoff_d && (pdoff_cnt_q != CNT_MAX)) begin
        pdoff_cnt_q <= pdoff_cnt_q + CNT_ONE;
      end
      if (blk_d && (pmm_blk_cnt_q != CNT_MAX)) begin
        pmm_blk_cnt_q <= pmm_blk_cnt_q + CNT_ONE;
      end
    end
  end

endmodule
`default_nettype wire

// [hw/pfdag_consts.vh]
// Purpose: Constants for the peripheral frame decode and access guard
// Assumes: 32-bit byte addresses, 4-bit master identifiers
// Notes:   Master ids other than the CPU are arbitrary local codes
//
// How it works
// RULE_01: Unimplemented location in a frame reads zero, write is dropped.
// RULE_02: DMA frame FFFF_F000..FFFF_F3FF, 1KB, drives select 4.
// RULE_03: Pin mux frame FFFF_EA00..FFFF_EBFF, 512B, drives select 2.
// RULE_04: First clock comparator frame at FFFF_EC00, 256B, select 3.
// RULE_05: Select 5 serves four 256B frames from FFFF_F400 to FFFF_F7FF.
// RULE_06: Select 6 serves three 256B frames from FFFF_F800 to FFFF_FAFF.
// RULE_07: Select 7 serves four 256B frames from FFFF_FC00 to FFFF_FFFF.
// RULE_08: CPU reads reach every slave group in either mode.
// RULE_09: CPU writes refused at flash secondary port, granted elsewhere.
// RULE_10: DMA, overlay and data modification units reach every group, user mode.
// RULE_11: Debug port is privileged and reaches every slave group.
// RULE_12: Both timer transfer units privileged, denied flash secondary port only.
// RULE_13: Ethernet master reaches only program flash/RAM and external slaves.
// RULE_14: Power manager writes accepted only from master id 1.
// RULE_15: Other masters may read power manager registers; writes change nothing.
// RULE_16: Debug mode bypasses the master id check on power manager writes.
// RULE_17: Access to a powered-off module ends in a bus error.
// RULE_18: Matrix-refused access gets an error and leaves the slave untouched.
`ifndef PFDAG_CONSTS_VH
`define PFDAG_CONSTS_VH

// ----------------------------------------
// Master identifiers
// ----------------------------------------
`define PFDAG_MID_CPU    4'h1
`define PFDAG_MID_DMA    4'h2
`define PFDAG_MID_OVL    4'h3
`define PFDAG_MID_DMOD   4'h4
`define PFDAG_MID_DBG    4'h5
`define PFDAG_MID_TTUA   4'h6
`define PFDAG_MID_TTUB   4'h7
`define PFDAG_MID_ETH    4'h8

// ----------------------------------------
// Slave groups of the permission matrix
// ----------------------------------------
`define PFDAG_GRP_FLASH2 3'h0
`define PFDAG_GRP_PFLASH 3'h1
`define PFDAG_GRP_CRC    3'h2
`define PFDAG_GRP_EXT    3'h3
`define PFDAG_GRP_PERIPH 3'h4

// Group address ranges, anything else is peripheral/system
`define PFDAG_FLASH2_LO  32'hF000_0000
`define PFDAG_FLASH2_HI  32'hF07F_FFFF
`define PFDAG_PFLASH_LO  32'h0000_0000
`define PFDAG_PFLASH_HI  32'h0FFF_FFFF
`define PFDAG_CRC_LO     32'hFE00_0000
`define PFDAG_CRC_HI     32'hFEFF_FFFF
`define PFDAG_EXT_LO     32'h6000_0000
`define PFDAG_EXT_HI     32'hDFFF_FFFF

// ----------------------------------------
// Frame ranges per peripheral select
// ----------------------------------------
`define PFDAG_PS2_LO     32'hFFFF_EA00
`define PFDAG_PS2_HI     32'hFFFF_EBFF
`define PFDAG_PS3_LO     32'hFFFF_EC00
`define PFDAG_PS3_HI     32'hFFFF_ECFF
`define PFDAG_PS4_LO     32'hFFFF_F000
`define PFDAG_PS4_HI     32'hFFFF_F3FF
`define PFDAG_PS5_LO     32'hFFFF_F400
`define PFDAG_PS5_HI     32'hFFFF_F7FF
`define PFDAG_PS6_LO     32'hFFFF_F800
`define PFDAG_PS6_HI     32'hFFFF_FAFF
`define PFDAG_PS7_LO     32'hFFFF_FC00
`define PFDAG_PS7_HI     32'hFFFF_FFFF

// Power domain manager frame
`define PFDAG_PMM_LO     32'hFFFF_0000
`define PFDAG_PMM_HI     32'hFFFF_01FF

// Number of decoded select lines (2..7)
`define PFDAG_NSEL       6
`define PFDAG_CNT_W      8

`endif

// [hw/pfdag_frame_decode.v]
// Purpose: Address to frame select and slave group decode
// Assumes: Pure combinational, same clock as the caller
// Notes:   Select bit i stands for peripheral select i+2
`timescale 1ns/1ps
`default_nettype none
`include "pfdag_consts.vh"

module pfdag_frame_decode (
  // Address in
  input  wire [31:0]             addr,
  // Decode out
  output wire [`PFDAG_NSEL-1:0]  sel,
  output wire                    in_frame,
  output wire                    is_pmm,
  output reg  [2:0]              group
);

  // ----------------------------------------
  // Frame table, select 7 in the top word
  // ----------------------------------------
  localparam [32*`PFDAG_NSEL-1:0] FR_LO = {
    `PFDAG_PS7_LO, `PFDAG_PS6_LO, `PFDAG_PS5_LO,
    `PFDAG_PS4_LO, `PFDAG_PS3_LO, `PFDAG_PS2_LO};
  localparam [32*`PFDAG_NSEL-1:0] FR_HI = {
    `PFDAG_PS7_HI, `PFDAG_PS6_HI, `PFDAG_PS5_HI,
    `PFDAG_PS4_HI, `PFDAG_PS3_HI, `PFDAG_PS2_HI};

  // One range compare per select line
  genvar i;
  generate
    for (i = 0; i < `PFDAG_NSEL; i = i + 1) begin : g_sel
      assign sel[i] = (addr >= FR_LO[32*i +: 32]) &&
                      (addr <= FR_HI[32*i +: 32]); // [RULE_02] [RULE_03] [RULE_04] [RULE_05] [RULE_06] [RULE_07]
    end
  endgenerate

  assign in_frame = |sel;
  assign is_pmm   = (addr >= `PFDAG_PMM_LO) && (addr <= `PFDAG_PMM_HI);

  // Slave group of the permission matrix
  always @* begin
    if ((addr >= `PFDAG_FLASH2_LO) && (addr <= `PFDAG_FLASH2_HI)) begin
      group = `PFDAG_GRP_FLASH2;
    end else if (addr <= `PFDAG_PFLASH_HI) begin
      group = `PFDAG_GRP_PFLASH;
    end else if ((addr >= `PFDAG_CRC_LO) && (addr <= `PFDAG_CRC_HI)) begin
      group = `PFDAG_GRP_CRC;
    end else if ((addr >= `PFDAG_EXT_LO) && (addr <= `PFDAG_EXT_HI)) begin
      group = `PFDAG_GRP_EXT;
    end else begin
      group = `PFDAG_GRP_PERIPH;
    end
  end

endmodule
`default_nettype wire

// [verification/pfdag_guard_assertions.sv]
// Purpose: Port-level checks on the frame decode and access guard
// Assumes: One clock, rst asynchronous and active high
// Notes:   Bound to the guard from the top of the bench
`timescale 1ns/1ps
`default_nettype none
`include "pfdag_consts.vh"
module pfdag_chk (
  // Clock, reset, request
  input wire logic                   clock,
  input wire logic                   rst,
  input wire logic                   req_valid,
  input wire logic [3:0]             req_master_id,
  input wire logic [31:0]            req_addr,
  input wire logic                   debug_mode,
  // Response, slave side, events
  input wire logic                   rsp_valid_q,
  input wire logic                   rsp_err_q,
  input wire logic [31:0]            rsp_rdata_q,
  input wire logic                   slv_rd,
  input wire logic                   slv_wr,
  input wire logic [`PFDAG_NSEL-1:0] slv_sel_q,
  input wire logic                   slv_pmm_sel_q,
  input wire logic                   slv_priv_q,
  input wire logic                   slv_hit,
  input wire logic [31:0]            slv_rdata,
  input wire logic                   deny_evt_q,
  input wire logic                   pdoff_evt_q,
  input wire logic                   pmm_blk_evt_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Cycles that debug mode has stayed low, saturating
  logic [2:0] dbg_lo_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst || debug_mode) begin
      dbg_lo_q <= 3'h0;
    end else if (dbg_lo_q != 3'h7) begin
      dbg_lo_q <= dbg_lo_q + 3'h1;
    end
  end
  sequence s_no_strobe;
    !slv_rd && !slv_wr && slv_sel_q == '0;
  endsequence
  sequence s_err_rsp;
    rsp_valid_q && rsp_err_q && rsp_rdata_q == 32'h0000_0000;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_rsp_latency: assert property (rsp_valid_q == $past(req_valid, 2))
    else $error("response not two cycles after request");
  a_deny_err: assert property (deny_evt_q |-> s_no_strobe ##1 s_err_rsp)
    else $error("denied access not refused with error");
  a_pdoff_err: assert property (pdoff_evt_q |-> s_no_strobe ##1 s_err_rsp)
    else $error("powered-off access not refused with error");
  a_pmm_blocked: assert property (pmm_blk_evt_q |-> !slv_wr ##1 rsp_valid_q && !rsp_err_q)
    else $error("blocked power write reached slave or erred");
  a_miss_zero: assert property (slv_sel_q != '0 && !slv_hit |->
    !slv_rd && !slv_wr ##1 !rsp_err_q && rsp_rdata_q == 32'h0000_0000)
    else $error("unowned location not zero and silent");
  a_read_data: assert property (slv_rd && slv_sel_q != '0 |=> rsp_rdata_q == $past(slv_rdata))
    else $error("read data not returned");
  a_sel_onehot: assert property ($onehot0(slv_sel_q))
    else $error("more than one select");
  a_pmm_cpu: assert property (slv_wr && slv_pmm_sel_q && dbg_lo_q == 3'h7 |->
    $past(req_master_id) == 4'h1)
    else $error("power write from non-cpu master");
  a_eth_periph: assert property ($past(req_valid) && $past(req_master_id) == 4'h8 &&
    $past(req_addr) >= 32'hFFFF_0000 |-> deny_evt_q)
    else $error("ethernet reached peripheral frame");
  a_dbg_priv: assert property (slv_sel_q != '0 && $past(req_master_id) == 4'h5 |-> slv_priv_q)
    else $error("debug access not privileged");
endmodule
`default_nettype wire

// [verification/pfdag_slave.sv]
// Purpose: Behavioural peripheral slave behind the guard
// Assumes: Answers combinationally in the strobe cycle
// Notes:   Upper half of each 256B frame is left unowned
`timescale 1ns/1ps
`default_nettype none
module pfdag_slave (
  // Access from the guard
  input  wire logic [31:0] addr,
  // Answer
  output logic             hit,
  output logic [31:0]      rdata,
  output logic             err
);
  // Ownership and data pattern; unowned words drive garbage
  assign hit   = ~addr[7];
  assign rdata = hit ? (addr ^ 32'hC3C3_3C3C) : ~addr;
  assign err   = 1'b0;
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the frame decode and access guard
// Assumes: Requests one at a time, then a back-to-back burst
// Notes:   Expectations come from the bench functions below
`timescale 1ns/1ps
`default_nettype none
`include "pfdag_consts.vh"
module tb_top;
  logic clock, rst, req_valid, req_write, req_cpu_priv, debug_mode;
  logic [3:0] req_master_id;
  logic [31:0] req_addr, req_wdata, rsp_rdata_q, slv_addr_q, slv_wdata_q, slv_rdata;
  logic rsp_valid_q, rsp_err_q, slv_rd, slv_wr, slv_pmm_sel_q, slv_other_q, slv_priv_q;
  logic slv_hit, slv_err, deny_evt_q, pdoff_evt_q, pmm_blk_evt_q;
  logic [5:0] slv_sel_q, pd_off;
  logic [7:0] deny_cnt_q, pdoff_cnt_q, pmm_blk_cnt_q;
  logic [31:0] r, seed = 32'h0000_5d5a;
  int error_cnt = 0, n_checks = 0, n_deny = 0, n_off = 0, n_blk = 0, i;
  // Frame bases in the top page, and frame edges
  logic [15:0] fb [16] = '{16'hEA00, 16'hEB00, 16'hEC00, 16'hF000, 16'hF300, 16'hF400,
    16'hF500, 16'hF600, 16'hF700, 16'hF800, 16'hF900, 16'hFA00, 16'hFC00, 16'hFF00,
    16'h0000, 16'hFB00};
  logic [15:0] eb [6] = '{16'hEBFC, 16'hECFC, 16'hED00, 16'hF3FC, 16'hFAFC, 16'hFFFC};
  logic [31:0] gb [4] = '{32'hF000_0000, 32'h0000_0000, 32'hFE00_0000, 32'h6000_0000};
  pfdag_guard dut (.*);
  pfdag_slave u_slv (.addr(slv_addr_q), .hit(slv_hit), .rdata(slv_rdata), .err(slv_err));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // ----------------------------------------
  // Bench functions
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [5:0] fsel(input logic [31:0] a);
    return {a >= `PFDAG_PS7_LO, a >= `PFDAG_PS6_LO && a <= `PFDAG_PS6_HI,
      a >= `PFDAG_PS5_LO && a <= `PFDAG_PS5_HI, a >= `PFDAG_PS4_LO && a <= `PFDAG_PS4_HI,
      a >= `PFDAG_PS3_LO && a <= `PFDAG_PS3_HI, a >= `PFDAG_PS2_LO && a <= `PFDAG_PS2_HI};
  endfunction
  function automatic logic grant(input logic [3:0] m, input logic w, input logic [31:0] a);
    logic f2;
    f2 = a >= `PFDAG_FLASH2_LO && a <= `PFDAG_FLASH2_HI;
    case (m)
      4'h1: grant = !(w && f2);
      4'h2, 4'h3, 4'h4, 4'h5: grant = 1'b1;
      4'h6, 4'h7: grant = !f2;
      4'h8: grant = a <= `PFDAG_PFLASH_HI || (a >= `PFDAG_EXT_LO && a <= `PFDAG_EXT_HI);
      default: grant = 1'b0;
    endcase
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  // One access, checked in the strobe cycle and the answer cycle
  task automatic xfer(input logic [3:0] m, input logic w, input logic [31:0] a);
    logic g, pm, off, blk, st, fr;
    logic [5:0] es;
    logic [31:0] wd;
    g = grant(m, w, a);
    es = fsel(a);
    pm = a >= `PFDAG_PMM_LO && a <= `PFDAG_PMM_HI;
    off = g && |(es & pd_off);
    blk = g && w && pm && m != 4'h1 && !debug_mode;
    fr = |es || pm;
    st = g && !off && !blk && fr && !a[7];
    n_deny += int'(!g);
    n_off += int'(off);
    n_blk += int'(blk);
    wd = rnd();
    @(posedge clock) #1;
    req_valid = 1'b1;
    req_write = w;
    req_master_id = m;
    req_addr = a;
    req_cpu_priv = r[0];
    req_wdata = wd;
    @(posedge clock) #1;
    req_valid = 1'b0;
    chk("sel", {26'h0, g && !off ? es : 6'h00}, {26'h0, slv_sel_q});
    if (fr) chk("strobe", {30'h0, st && !w, st && w}, {30'h0, slv_rd, slv_wr});
    if (st) chk("priv", {31'h0, m == 4'h1 ? r[0] : m inside {5, 6, 7}}, {31'h0, slv_priv_q});
    chk("deny", {31'h0, !g}, {31'h0, deny_evt_q});
    chk("pdoff", {31'h0, off}, {31'h0, pdoff_evt_q});
    chk("pmmblk", {31'h0, blk}, {31'h0, pmm_blk_evt_q});
    chk("pmmsel", {31'h0, g && !blk && pm}, {31'h0, slv_pmm_sel_q});
    chk("other", {31'h0, g && !fr}, {31'h0, slv_other_q});
    chk("addr", a, slv_addr_q);
    chk("wdata", wd, slv_wdata_q);
    @(posedge clock) #1;
    chk("err", {30'h0, 1'b1, !g || off}, {30'h0, rsp_valid_q, rsp_err_q});
    if (fr || !g) chk("rdata", st && !w ? a ^ 32'hC3C3_3C3C : 32'h0, rsp_rdata_q);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #125000;
    error_cnt++;
    final_report();
  end
  initial begin
    {rst, req_valid, req_write, req_cpu_priv, debug_mode, r} = {5'b10000, 32'h0};
    {req_master_id, req_addr, req_wdata, pd_off} = '0;
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    for (i = 0; i < 6; i++) xfer(4'h1, i[0], {16'hFFFF, eb[i]});
    $display("test corner done");
    for (i = 0; i < 300; i++) begin
      r = rnd();
      pd_off = r[3:1] == 3'h0 ? r[9:4] : 6'h00;
      xfer(r[13:10], r[14], r[27] ? gb[r[29:28]] : {16'hFFFF, fb[r[18:15]] | {6'h0, r[26:19], 2'b0}});
    end
    chk("deny_cnt", n_deny > 255 ? 32'd255 : n_deny, {24'h0, deny_cnt_q});
    chk("pdoff_cnt", n_off > 255 ? 32'd255 : n_off, {24'h0, pdoff_cnt_q});
    $display("test random done");
    pd_off = 6'h00;
    for (i = 1; i < 9; i++) xfer(i[3:0], 1'b1, 32'hFFFF_0010);
    debug_mode = 1'b1;
    repeat (4) @(posedge clock);
    xfer(4'h5, 1'b1, 32'hFFFF_0010);
    debug_mode = 1'b0;
    chk("blk_cnt", n_blk > 255 ? 32'd255 : n_blk, {24'h0, pmm_blk_cnt_q});
    $display("test power writes done");
    for (i = 0; i < 40; i++) begin
      @(posedge clock) #1;
      r = rnd();
      {req_valid, req_write, req_master_id, req_cpu_priv} = r[31:25];
      req_addr = {16'hFFFF, fb[r[3:0]] | {8'h0, r[11:4]}};
      pd_off = r[17:12] & r[23:18];
    end
    @(posedge clock) #1;
    req_valid = 1'b0;
    repeat (4) @(posedge clock);
    $display("test burst done");
    final_report();
  end
endmodule
bind pfdag_guard pfdag_chk u_chk (.*);
`default_nettype wire
